// ---- src/vsf_top.sv ----
// Vibration suppression filter settings, adaptive notch and damping select
//
// Behaviour
// - Adaptive selection takes 0 to 4, resets to 0; 0 disables adaptation.
// - Selection 1: one adaptive filter, frequency frozen after adaptation.
// - Selection 2: two adaptive filters, both frozen after adaptation.
// - Selection 3: one adaptive filter adapting continuously.
// - Selection 4: two adaptive filters, exactly one adapting continuously.
// - Notch 1 frequency 50 to 5000 Hz, reset 5000.
// - Notch 1 width 0 to 20, reset 2.
// - Notch 1 depth 0 to 99, reset 0.
// - Notch 2 has the same settings, ranges and resets as notch 1.
// - Adaptive result writes notch 3 and 4 settings only while that filter is adapting, not while frozen.
// - Damping switching method takes 0 to 3, resets to 0.
// - Method 1: filters 1,3 when input A open, 2,4 when shorted.
// - Method 2: one filter chosen by inputs A and B.
// - Method 3: filters 1,3 forward, 2,4 reverse.
`timescale 1ns/100ps
module vsf_top
  import vsf_pkg::*;
(
  input wire logic clk_i, // System clock, 50 MHz
  input wire logic rst_i, // Asynchronous reset, active high
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB write
  input wire logic [ADDR_W-1:0] paddr_i, // APB byte address
  input wire logic [DATA_W-1:0] pwdata_i, // APB write data
  output logic [DATA_W-1:0] prdata_o, // APB read data
  output logic pready_o, // APB ready
  output logic pslverr_o, // APB error
  input wire logic damping_select_in_a_i, // Select input A, high = shorted
  input wire logic damping_select_in_b_i, // Select input B, high = shorted
  input wire logic reverse_dir_i, // High during reverse travel
  input wire logic adapt_valid_i, // Adaptation result strobe
  input wire logic adapt_index_i, // Adaptive filter the result is for
  input wire vsf_notch_t adapt_result_i, // Estimated notch setting
  input wire logic adapt_done_i, // Adaptation of that filter converged
  output vsf_notch_t [NUM_NOTCH-1:0] notch_o, // Notch settings to the loop
  output logic [NUM_ADAPT-1:0] adapt_run_o, // Adaptive filter adapting
  output logic [NUM_ADAPT-1:0] adapt_hold_o, // Adaptive filter frozen
  output logic [3:0] damp_en_o // Damping filter enables 4..1
);

  logic [2:0] adapt_sel;
  logic [1:0] damp_method;
  vsf_adapt_state_t ad_state [NUM_ADAPT];
  logic restart;
  logic access;
  logic wr_ok;
  logic next_err;
  logic [DATA_W-1:0] next_rdata;
  logic hit_notch;
  logic [1:0] hit_idx;
  logic [1:0] hit_field;
  logic [NUM_ADAPT-1:0] ad_en;
  logic [NUM_ADAPT-1:0] ad_cont;

  // Byte address of one notch field
  function automatic logic [7:0] notch_addr(input int unsigned n,
                                            input logic [7:0] f);
    notch_addr = OFF_NOTCH_BASE + 8'(n) * NOTCH_STRIDE + f;
  endfunction

  // Adaptive filters enabled by a selection value
  function automatic logic [1:0] adapt_enabled(input logic [2:0] m);
    case (m)
      ADAPT_ONE_HOLD: adapt_enabled = 2'h1;
      ADAPT_TWO_HOLD: adapt_enabled = 2'h3;
      ADAPT_ONE_CONT: adapt_enabled = 2'h1;
      ADAPT_TWO_MIXED: adapt_enabled = 2'h3;
      default: adapt_enabled = 2'h0;
    endcase
  endfunction

  // Adaptive filters that never freeze
  function automatic logic [1:0] adapt_continuous(input logic [2:0] m);
    case (m)
      ADAPT_ONE_CONT: adapt_continuous = 2'h1;
      ADAPT_TWO_MIXED: adapt_continuous = 2'h2;
      default: adapt_continuous = 2'h0;
    endcase
  endfunction

  // Whether a written value fits a field's range
  function automatic logic field_ok(input logic [1:0] f,
                                    input logic [DATA_W-1:0] v);
    case (f)
      2'h0: field_ok = v >= 32'(FREQ_MIN) && v <= 32'(FREQ_MAX);
      2'h1: field_ok = v <= 32'(WIDTH_MAX);
      default: field_ok = v <= 32'(DEPTH_MAX);
    endcase
  endfunction

  // Bound an adaptation result to the legal ranges
  function automatic vsf_notch_t clamp(input vsf_notch_t r);
    vsf_notch_t c;
    c = r;
    if (r.freq < FREQ_MIN) begin
      c.freq = FREQ_MIN;
    end else if (r.freq > FREQ_MAX) begin
      c.freq = FREQ_MAX;
    end
    if (r.width > WIDTH_MAX) begin
      c.width = WIDTH_MAX;
    end
    if (r.depth > DEPTH_MAX) begin
      c.depth = DEPTH_MAX;
    end
    clamp = c;
  endfunction

  assign ad_en = adapt_enabled(adapt_sel);
  assign ad_cont = adapt_continuous(adapt_sel);
  assign access = psel_i && penable_i;
  assign pready_o = 1'b1;

  // Locate a notch field register
  always_comb begin
    hit_notch = 1'b0;
    hit_idx = 2'h0;
    hit_field = 2'h0;
    for (int n = 0; n < NUM_NOTCH; n++) begin
      if (paddr_i == notch_addr(n, FIELD_FREQ)) begin
        hit_notch = 1'b1;
        hit_idx = 2'(n);
        hit_field = 2'h0;
      end
      if (paddr_i == notch_addr(n, FIELD_WIDTH)) begin
        hit_notch = 1'b1;
        hit_idx = 2'(n);
        hit_field = 2'h1;
      end
      if (paddr_i == notch_addr(n, FIELD_DEPTH)) begin
        hit_notch = 1'b1;
        hit_idx = 2'(n);
        hit_field = 2'h2;
      end
    end
  end

  // Decode access legality and read data
  always_comb begin
    next_err = 1'b0;
    next_rdata = '0;
    if (paddr_i == OFF_ADAPT_SEL) begin
      next_rdata = 32'(adapt_sel);
      if (pwrite_i && pwdata_i > 32'(ADAPT_SEL_MAX)) begin
        next_err = 1'b1;
      end
    end else if (paddr_i == OFF_DAMP_METHOD) begin
      next_rdata = 32'(damp_method);
      if (pwrite_i && pwdata_i > 32'(DAMP_METHOD_MAX)) begin
        next_err = 1'b1;
      end
    end else if (paddr_i == OFF_STATUS) begin
      next_rdata[ST_DAMP_LSB +: 4] = damp_en_o;
      next_rdata[ST_RUN_LSB +: NUM_ADAPT] = adapt_run_o;
      next_rdata[ST_HOLD_LSB +: NUM_ADAPT] = adapt_hold_o;
      next_rdata[ST_SEL_LSB +: 2] = {damping_select_in_b_i,
                                     damping_select_in_a_i};
      next_rdata[ST_METHOD_LSB] = reverse_dir_i;
      next_err = pwrite_i;
    end else if (hit_notch) begin
      case (hit_field)
        2'h0: next_rdata = 32'(notch_o[hit_idx].freq);
        2'h1: next_rdata = 32'(notch_o[hit_idx].width);
        default: next_rdata = 32'(notch_o[hit_idx].depth);
      endcase
      if (pwrite_i && !field_ok(hit_field, pwdata_i)) begin
        next_err = 1'b1;
      end
      // Notch 3 and 4 belong to the adaptation while their adaptive filter is enabled, adapting or frozen
      if (pwrite_i && hit_idx >= 2'h2 && ad_en[hit_idx[0]]) begin
        next_err = 1'b1;
      end
    end else begin
      next_err = 1'b1;
    end
  end

  assign wr_ok = access && pwrite_i && !next_err;
  assign prdata_o = (access && !pwrite_i) ? next_rdata : '0;
  assign pslverr_o = access && next_err;

  // Adaptive filter selection register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      adapt_sel <= ADAPT_SEL_RST;
    end else if (wr_ok && paddr_i == OFF_ADAPT_SEL) begin
      adapt_sel <= pwdata_i[2:0];
    end
  end

  // A new selection restarts adaptation from scratch
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      restart <= 1'b0;
    end else begin
      restart <= wr_ok && paddr_i == OFF_ADAPT_SEL;
    end
  end

  // Damping switching method register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      damp_method <= DAMP_METHOD_RST;
    end else if (wr_ok && paddr_i == OFF_DAMP_METHOD) begin
      damp_method <= pwdata_i[1:0];
    end
  end

  // Per filter adaptation state: adapt, then freeze unless continuous
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int k = 0; k < NUM_ADAPT; k++) begin
        ad_state[k] <= AD_OFF;
      end
    end else begin
      for (int k = 0; k < NUM_ADAPT; k++) begin
        case (ad_state[k])
          AD_OFF: begin
            if (ad_en[k]) begin
              ad_state[k] <= AD_ADAPT;
            end
          end
          AD_ADAPT: begin
            if (!ad_en[k]) begin
              ad_state[k] <= AD_OFF;
            end else if (adapt_valid_i && adapt_done_i &&
                         adapt_index_i == 1'(k) && !ad_cont[k]) begin
              ad_state[k] <= AD_HOLD;
            end
          end
          AD_HOLD: begin
            if (!ad_en[k]) begin
              ad_state[k] <= AD_OFF;
            end else if (restart || ad_cont[k]) begin
              ad_state[k] <= AD_ADAPT;
            end
          end
          default: ad_state[k] <= AD_OFF;
        endcase
      end
    end
  end

  // Status toward the loop
  always_comb begin
    for (int k = 0; k < NUM_ADAPT; k++) begin
      adapt_run_o[k] = ad_state[k] == AD_ADAPT;
      adapt_hold_o[k] = ad_state[k] == AD_HOLD;
    end
  end

  // Notch settings: software writes, adaptation fills notch 3 and 4
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int n = 0; n < NUM_NOTCH; n++) begin
        notch_o[n].freq <= FREQ_RST;
        notch_o[n].width <= WIDTH_RST;
        notch_o[n].depth <= DEPTH_RST;
      end
    end else begin
      if (wr_ok && hit_notch) begin
        case (hit_field)
          2'h0: notch_o[hit_idx].freq <= pwdata_i[FREQ_W-1:0];
          2'h1: notch_o[hit_idx].width <= pwdata_i[WIDTH_W-1:0];
          default: notch_o[hit_idx].depth <= pwdata_i[DEPTH_W-1:0];
        endcase
      end
      if (adapt_valid_i && ad_state[adapt_index_i] == AD_ADAPT) begin
        notch_o[{1'b1, adapt_index_i}] <= clamp(adapt_result_i);
      end
    end
  end

  // Damping filter set selection
  vsf_damp_sel u_damp_sel (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .method_i(damp_method),
    .sel_a_i(damping_select_in_a_i),
    .sel_b_i(damping_select_in_b_i),
    .reverse_i(reverse_dir_i),
    .damp_en_o(damp_en_o)
  );

endmodule

// ---- src/vsf_pkg.sv ----
// Shared constants and types for the vibration suppression filter block
package vsf_pkg;

  // APB geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFF_ADAPT_SEL = 8'h00;
  localparam logic [7:0] OFF_NOTCH_BASE = 8'h04;
  localparam logic [7:0] NOTCH_STRIDE = 8'h0C;
  localparam logic [7:0] FIELD_FREQ = 8'h00;
  localparam logic [7:0] FIELD_WIDTH = 8'h04;
  localparam logic [7:0] FIELD_DEPTH = 8'h08;
  localparam logic [7:0] OFF_DAMP_METHOD = 8'h34;
  localparam logic [7:0] OFF_STATUS = 8'h38;

  // Field widths and filter counts
  localparam int unsigned FREQ_W = 13;
  localparam int unsigned WIDTH_W = 5;
  localparam int unsigned DEPTH_W = 7;
  localparam int unsigned NUM_NOTCH = 4;
  localparam int unsigned NUM_ADAPT = 2;

  // Setting ranges
  localparam logic [2:0] ADAPT_SEL_MAX = 3'h4;
  localparam logic [12:0] FREQ_MIN = 13'h0032;
  localparam logic [12:0] FREQ_MAX = 13'h1388;
  localparam logic [4:0] WIDTH_MAX = 5'h14;
  localparam logic [6:0] DEPTH_MAX = 7'h63;
  localparam logic [1:0] DAMP_METHOD_MAX = 2'h3;

  // Reset values
  localparam logic [2:0] ADAPT_SEL_RST = 3'h0;
  localparam logic [12:0] FREQ_RST = 13'h1388;
  localparam logic [4:0] WIDTH_RST = 5'h02;
  localparam logic [6:0] DEPTH_RST = 7'h00;
  localparam logic [1:0] DAMP_METHOD_RST = 2'h0;

  // Status register bit positions
  localparam int unsigned ST_DAMP_LSB = 0;
  localparam int unsigned ST_RUN_LSB = 4;
  localparam int unsigned ST_HOLD_LSB = 6;
  localparam int unsigned ST_SEL_LSB = 8;
  localparam int unsigned ST_METHOD_LSB = 12;

  // Adaptive filter selection values
  localparam logic [2:0] ADAPT_ONE_HOLD = 3'h1;
  localparam logic [2:0] ADAPT_TWO_HOLD = 3'h2;
  localparam logic [2:0] ADAPT_ONE_CONT = 3'h3;
  localparam logic [2:0] ADAPT_TWO_MIXED = 3'h4;

  // Damping switching methods
  localparam logic [1:0] DAMP_ALL = 2'h0;
  localparam logic [1:0] DAMP_BY_A = 2'h1;
  localparam logic [1:0] DAMP_BY_AB = 2'h2;
  localparam logic [1:0] DAMP_BY_DIR = 2'h3;

  // One notch filter setting as seen by the control loop
  typedef struct packed {
    logic [FREQ_W-1:0] freq;
    logic [WIDTH_W-1:0] width;
    logic [DEPTH_W-1:0] depth;
  } vsf_notch_t;

  // State of one adaptive filter
  typedef enum logic [1:0] {
    AD_OFF,
    AD_ADAPT,
    AD_HOLD
  } vsf_adapt_state_t;

endpackage

// ---- src/vsf_damp_sel.sv ----
// Damping filter set selection from method, select inputs and direction
`timescale 1ns/100ps
module vsf_damp_sel
  import vsf_pkg::*;
(
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Asynchronous reset, active high
  input wire logic [1:0] method_i, // Switching method setting
  input wire logic sel_a_i, // First select input, high when shorted
  input wire logic sel_b_i, // Second select input, high when shorted
  input wire logic reverse_i, // High during reverse travel
  output logic [3:0] damp_en_o // Enables of damping filters 4..1
);

  logic [3:0] next_damp_en;

  // Decode the active damping filter set
  always_comb begin
    case (method_i)
      DAMP_ALL: next_damp_en = 4'hF;
      DAMP_BY_A: next_damp_en = sel_a_i ? 4'hA : 4'h5;
      DAMP_BY_AB: begin
        case ({sel_b_i, sel_a_i})
          2'h0: next_damp_en = 4'h1;
          2'h1: next_damp_en = 4'h2;
          2'h2: next_damp_en = 4'h4;
          default: next_damp_en = 4'h8;
        endcase
      end
      DAMP_BY_DIR: next_damp_en = reverse_i ? 4'hA : 4'h5;
      default: next_damp_en = 4'hF;
    endcase
  end

  // Registered enables toward the loop
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      damp_en_o <= 4'h0;
    end else begin
      damp_en_o <= next_damp_en;
    end
  end

endmodule

// ---- verification/vsf_top_assertions.sv ----
// Port-level checks for the vibration suppression block
`timescale 1ns/100ps
module vsf_top_assertions
  import vsf_pkg::*;
(
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Reset, active high
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pslverr_o, // APB error
  input wire logic damping_select_in_a_i, // Select input A
  input wire logic damping_select_in_b_i, // Select input B
  input wire logic reverse_dir_i, // Reverse travel
  input wire logic adapt_valid_i, // Result strobe
  input wire logic adapt_index_i, // Result filter
  input wire vsf_notch_t adapt_result_i, // Result value
  input wire vsf_notch_t [NUM_NOTCH-1:0] notch_o, // Notch settings
  input wire logic [NUM_ADAPT-1:0] adapt_run_o, // Adapting
  input wire logic [NUM_ADAPT-1:0] adapt_hold_o, // Frozen
  input wire logic [3:0] damp_en_o // Damping enables
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Result needs no clamping
  wire res_ok = adapt_result_i.freq >= FREQ_MIN &&
    adapt_result_i.freq <= FREQ_MAX && adapt_result_i.width <= WIDTH_MAX
    && adapt_result_i.depth <= DEPTH_MAX;
  wire quiet = !psel_i && !penable_i;
  // Reset leaves notch 1 and 2 at their defaults
  property p_rst_val;
    $fell(rst_i) |-> notch_o[0] == {FREQ_RST, WIDTH_RST, DEPTH_RST} &&
      notch_o[1] == {FREQ_RST, WIDTH_RST, DEPTH_RST};
  endproperty
  a_rst_val: assert property (p_rst_val)
    else $error("notch reset value wrong");
  property p_excl;
    (adapt_run_o & adapt_hold_o) == 2'h0;
  endproperty
  a_excl: assert property (p_excl)
    else $error("filter adapting and frozen at once");
  property p_pair;
    (adapt_run_o[1] || adapt_hold_o[1]) |->
      (adapt_run_o[0] || adapt_hold_o[0]);
  endproperty
  a_pair: assert property (p_pair)
    else $error("second filter alone");
  property p_load3;
    adapt_valid_i && !adapt_index_i && adapt_run_o[0] && res_ok
      |=> notch_o[2] == $past(adapt_result_i);
  endproperty
  a_load3: assert property (p_load3)
    else $error("notch 3 not loaded");
  property p_load4;
    adapt_valid_i && adapt_index_i && adapt_run_o[1] && res_ok
      |=> notch_o[3] == $past(adapt_result_i);
  endproperty
  a_load4: assert property (p_load4)
    else $error("notch 4 not loaded");
  property p_freeze;
    adapt_hold_o[0] |=> $stable(notch_o[2]);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("frozen notch 3 moved");
  property p_err;
    pslverr_o |-> psel_i && penable_i;
  endproperty
  a_err: assert property (p_err)
    else $error("error outside access");
  property p_code;
    !$past(rst_i) |-> damp_en_o inside {4'hF, 4'h5, 4'hA, 4'h1, 4'h2,
      4'h4, 4'h8};
  endproperty
  a_code: assert property (p_code)
    else $error("illegal damping set");
  property p_dstable;
    (!rst_i && quiet && $stable({damping_select_in_a_i, damping_select_in_b_i,
      reverse_dir_i})) [*2] |=> $stable(damp_en_o);
  endproperty
  a_dstable: assert property (p_dstable)
    else $error("damping set moved without cause");
  property p_n1;
    !(psel_i && penable_i) |=> $stable(notch_o[0]);
  endproperty
  a_n1: assert property (p_n1)
    else $error("notch 1 moved without write");
  // Main scenarios reached
  c_hold: cover property (adapt_hold_o == 2'h3);
  c_err: cover property (pslverr_o);
  c_d8: cover property (damp_en_o == 4'h8);
endmodule
bind vsf_top vsf_top_assertions u_chk (.clk_i, .rst_i, .psel_i,
  .penable_i, .pslverr_o, .damping_select_in_a_i, .damping_select_in_b_i,
  .reverse_dir_i, .adapt_valid_i, .adapt_index_i, .adapt_result_i,
  .notch_o, .adapt_run_o, .adapt_hold_o, .damp_en_o);

// ---- verification/vsf_loop_model.sv ----
// Behavioural control loop and select wiring facing the block
`timescale 1ns/100ps
module vsf_loop_model
  import vsf_pkg::*;
(
  input wire logic clk_i, // System clock
  output logic sel_a_o, // Select A, high = shorted
  output logic sel_b_o, // Select B, high = shorted
  output logic rev_o, // Reverse travel
  output logic valid_o, // Result strobe
  output logic idx_o, // Result filter
  output vsf_notch_t res_o, // Result value
  output logic done_o // Converged
);
  // Idle outputs at time zero
  initial begin
    {sel_a_o, sel_b_o, rev_o, valid_o, idx_o, done_o} = 6'h00;
    res_o = '0;
  end
  // Contacts are only ever open or shorted
  task automatic wire_sel(input logic a, input logic b, input logic r);
    @(posedge clk_i);
    sel_a_o <= a;
    sel_b_o <= b;
    rev_o <= r;
  endtask
  // One strobe, then the result bus carries junk
  task automatic send(input logic i, input vsf_notch_t r, input logic d);
    @(posedge clk_i);
    valid_o <= 1'b1;
    idx_o <= i;
    res_o <= r;
    done_o <= d;
    @(posedge clk_i);
    valid_o <= 1'b0;
    idx_o <= ~i;
    res_o <= ~r;
    done_o <= ~d;
  endtask
endmodule

// ---- verification/vsf_top_bench.sv ----
// Self-checking bench for the vibration suppression block
`timescale 1ns/100ps
module vsf_top_bench;
  import vsf_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, q;
  logic pready_o, pslverr_o, e, sa, sb, rv, vl, ix, dn;
  vsf_notch_t rs, r, last3;
  vsf_notch_t [NUM_NOTCH-1:0] notch_o;
  logic [1:0] adapt_run_o, adapt_hold_o;
  logic [3:0] damp_en_o;
  logic [31:0] sh [2][3];
  int err_total = 0, tests_run = 0;
  always #10 clk_i = ~clk_i;
  vsf_top dut (.clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
    .damping_select_in_a_i(sa), .damping_select_in_b_i(sb),
    .reverse_dir_i(rv), .adapt_valid_i(vl), .adapt_index_i(ix),
    .adapt_result_i(rs), .adapt_done_i(dn), .notch_o, .adapt_run_o,
    .adapt_hold_o, .damp_en_o);
  vsf_loop_model loop (.clk_i, .sel_a_o(sa), .sel_b_o(sb), .rev_o(rv),
    .valid_o(vl), .idx_o(ix), .res_o(rs), .done_o(dn));
  // Expected limits, defaults and decodes
  function automatic int fmax(int f);
    return f == 0 ? 5000 : (f == 1 ? 20 : 99);
  endfunction
  function automatic int fmin(int f);
    return f == 0 ? 50 : 0;
  endfunction
  function automatic int frst(int f);
    return f == 0 ? 5000 : (f == 1 ? 2 : 0);
  endfunction
  function automatic logic [7:0] na(int n, int f);
    return OFF_NOTCH_BASE + NOTCH_STRIDE * 8'(n) + 8'(4 * f);
  endfunction
  function automatic logic [3:0] dexp(int m, logic a, logic b, logic r);
    case (m)
      0: return 4'hF;
      1: return a ? 4'hA : 4'h5;
      2: return 4'h1 << {b, a};
      default: return r ? 4'hA : 4'h5;
    endcase
  endfunction
  // Run before results, then {hold, run} once all have converged
  function automatic logic [5:0] aexp(int m);
    case (m)
      0: return 6'h00;
      1: return 6'h14;
      2: return 6'h3C;
      3: return 6'h11;
      default: return 6'h36;
    endcase
  endfunction
  // Adaptation results are bounded to the legal notch ranges
  function automatic vsf_notch_t lim(vsf_notch_t x);
    vsf_notch_t y;
    y = x;
    if (x.freq < FREQ_MIN) y.freq = FREQ_MIN;
    if (x.freq > FREQ_MAX) y.freq = FREQ_MAX;
    if (x.width > WIDTH_MAX) y.width = WIDTH_MAX;
    if (x.depth > DEPTH_MAX) y.depth = DEPTH_MAX;
    return y;
  endfunction
  task automatic chk(input string nm, input logic [31:0] s, x);
    tests_run++;
    if (s !== x) begin
      err_total++;
      $display("MISMATCH %s exp %h seen %h", nm, x, s);
    end
  endtask
  task automatic test_done();
    if (err_total == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // One APB transfer, waiting on ready with no bound of its own
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] rd, output logic er);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    // Wait for ready; only the watchdog ends a stuck transfer
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  // Watchdog against a hang
  initial begin
    #400000;
    err_total++;
    test_done();
  end
  // Main sequence
  initial begin
    int n, f, k, m;
    logic [31:0] v;
    logic [5:0] ax;
    v = $urandom(32'h9FC9);
    last3 = {FREQ_RST, WIDTH_RST, DEPTH_RST};
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    for (n = 0; n < 4; n++) begin
      for (f = 0; f < 3; f++) begin
        apb(1'b0, na(n, f), 32'h0, q, e);
        chk("notch rst", q, frst(f));
        if (n < 2) sh[n][f] = frst(f);
      end
    end
    apb(1'b0, OFF_ADAPT_SEL, 32'h0, q, e);
    chk("sel rst", q, 32'h0);
    apb(1'b0, OFF_DAMP_METHOD, 32'h0, q, e);
    chk("method rst", q, 32'h0);
    // Bounds, random legal and illegal values on notches 1 and 2
    for (n = 0; n < 2; n++) begin
      for (f = 0; f < 3; f++) begin
        for (k = 0; k < 5; k++) begin
          case (k)
            0: v = fmin(f);
            1: v = fmax(f);
            2: v = fmax(f) + 1;
            3: v = fmin(f) + $urandom_range(fmax(f) - fmin(f));
            default: v = f == 0 ? 49 : fmax(f) + 1 + $urandom_range(999);
          endcase
          apb(1'b1, na(n, f), v, q, e);
          chk("refused", e, v > fmax(f) || v < fmin(f));
          if (v <= fmax(f) && v >= fmin(f)) sh[n][f] = v;
          apb(1'b0, na(n, f), 32'h0, q, e);
          chk("readback", q, sh[n][f]);
        end
      end
      chk("notch out", notch_o[n], {sh[n][0][12:0], sh[n][1][4:0],
        sh[n][2][6:0]});
    end
    apb(1'b1, OFF_ADAPT_SEL, 32'h5, q, e);
    chk("sel 5", e, 1'b1);
    apb(1'b1, OFF_DAMP_METHOD, 32'h4, q, e);
    chk("method 4", e, 1'b1);
    apb(1'b1, 8'h3C, 32'h0, q, e);
    chk("unmapped", e, 1'b1);
    // Every method against select and direction combinations
    for (m = 0; m < 4; m++) begin
      apb(1'b1, OFF_DAMP_METHOD, m, q, e);
      for (k = 0; k < 11; k++) begin
        v = k < 8 ? k : $urandom_range(7);
        loop.wire_sel(v[0], v[1], v[2]);
        repeat (2) @(posedge clk_i);
        #1;
        chk("damp", damp_en_o, dexp(m, v[0], v[1], v[2]));
      end
    end
    apb(1'b0, OFF_STATUS, 32'h0, q, e);
    chk("status", {q[12], q[9:8], q[3:0]}, {v[2:0], dexp(3, v[0], v[1],
      v[2])});
    // Each adaptive selection: start, converge, then a late result
    for (m = 0; m < 5; m++) begin
      ax = aexp(m);
      apb(1'b1, OFF_ADAPT_SEL, m, q, e);
      repeat (3) @(posedge clk_i);
      #1 chk("run", adapt_run_o, ax[5:4]);
      for (k = 0; k < 2; k++) begin
        r.freq = FREQ_MIN + 13'($urandom_range(4950));
        r.width = 5'($urandom_range(20));
        r.depth = 7'($urandom_range(99));
        if (ax[4 + k]) begin
          loop.send(k[0], r, 1'b1);
          #1 chk("adapted", notch_o[2 + k], r);
          if (k == 0) last3 = r;
        end
      end
      repeat (2) @(posedge clk_i);
      #1 chk("hold", adapt_hold_o, ax[3:2]);
      chk("cont", adapt_run_o, ax[1:0]);
      loop.send(1'b0, ~r, 1'b1);
      if (m == 3) last3 = lim(~r);
      #1 chk("late", notch_o[2], last3);
    end
    apb(1'b1, na(2, 0), 32'h64, q, e);
    chk("notch 3 locked", e, 1'b1);
    apb(1'b1, OFF_ADAPT_SEL, 32'h0, q, e);
    repeat (3) @(posedge clk_i);
    apb(1'b1, na(2, 0), 32'h64, q, e);
    #1 chk("notch 3 free", e, 1'b0);
    chk("notch 3 value", notch_o[2].freq, 13'h0064);
    test_done();
  end
endmodule
